// ### rtl/dcd_defines.svh
// Constants of the debug command decoder: command codes, timing and sizes.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef DCD_DEFINES_SVH
`define DCD_DEFINES_SVH
`define DCD_CMD_RD_REV      8'h00
`define DCD_CMD_WR_CNT      8'h01
`define DCD_CMD_RD_STAT     8'h02
`define DCD_CMD_RD_CNT      8'h03
`define DCD_CMD_WR_CTL      8'h04
`define DCD_CMD_RD_CTL      8'h05
`define DCD_CMD_WR_PC       8'h06
`define DCD_CMD_RD_PC       8'h07
`define DCD_CMD_WR_REG      8'h08
`define DCD_CMD_RD_REG      8'h09
`define DCD_CMD_WR_PMEM     8'h0A
`define DCD_CMD_RD_PMEM     8'h0B
`define DCD_CMD_WR_DMEM     8'h0C
`define DCD_CMD_RD_DMEM     8'h0D
`define DCD_CMD_RD_CRC      8'h0E
`define DCD_CMD_RSVD_F      8'h0F
`define DCD_CMD_STEP        8'h10
`define DCD_CMD_STUFF       8'h11
`define DCD_CMD_EXEC        8'h12
`define DCD_CMD_WR_LINE     8'h18
`define DCD_CMD_RD_LINE     8'h19
`define DCD_CMD_RD_BAUD     8'h1B
`define DCD_CAL_CHAR        8'h80
`define DCD_BREAK_BITS      4'hA
`define DCD_FIFO_DEPTH      8
`define DCD_BAUD_W          12
`define DCD_BAUD_MAX        12'hFFF
`define DCD_RAM_BASE        12'h000
`define DCD_RAM_TOP         12'hEFF
`endif

// ### rtl/dcd_pkg.sv
// Types shared by the debug command decoder modules.
// Assumes the defines header sits in the include path.
`include "dcd_defines.svh"
package dcd_pkg;
    typedef enum logic [1:0] {
        DCD_OK,
        DCD_REF_RSVD,
        DCD_REF_STATE,
        DCD_REF_PROT
    } dcd_verdict_e;

    typedef struct packed {
        logic [7:0]  code;
        logic [11:0] addr;
        logic        hasAddr;
    } dcd_cmd_s;

    typedef struct packed {
        logic [7:0]   code;
        dcd_verdict_e verdict;
        logic         ramTarget;
    } dcd_result_s;
endpackage

// ### rtl/dcd_fifo.sv
// Parameterised synchronous FIFO with valid and ready on both sides.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module dcd_fifo #(
    parameter int WIDTH = 21,
    parameter int DEPTH = 8
) (
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] inData,
    input  wire logic             inValid,
    output logic                  inReady,
    output logic [WIDTH-1:0]      outData,
    output logic                  outValid,
    input  wire logic             outReady
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr;
    logic [AW-1:0]    rdPtr;
    logic [AW:0]      count;
    wire              doPush = inValid && inReady;
    wire              doPop  = outValid && outReady;

    assign inReady  = (count != (AW+1)'(DEPTH)) || doPop;
    assign outValid = (count != '0);
    assign outData  = mem[rdPtr];

    always_ff @(posedge clk_sys) begin
        if (doPush) begin
            mem[wrPtr] <= inData;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end else begin
            if (doPush) begin
                wrPtr <= (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + AW'(1);
            end
            if (doPop) begin
                rdPtr <= (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + AW'(1);
            end
            count <= count + (AW+1)'(doPush) - (AW+1)'(doPop);
        end
    end
endmodule
`default_nettype wire

// ### rtl/dcd_autobaud.sv
// Break detector and autobaud measurement of the serial debug line.
// Assumes rxLine is already synchronised to clk_sys.
`timescale 1ns/1ps
`default_nettype none
`include "dcd_defines.svh"
module dcd_autobaud
    import dcd_pkg::*;
#(
    parameter int BAUD_W = `DCD_BAUD_W
) (
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    input  wire logic              rxLine,
    output logic [BAUD_W-1:0]      baudReload,
    output logic                   baudLocked,
    output logic                   breakSeen
);
    typedef enum logic [1:0] {
        AB_IDLE,
        AB_MEASURE,
        AB_LOCKED
    } dcd_ab_e;

    dcd_ab_e           state;
    dcd_ab_e           next_state;
    logic [BAUD_W-1:0] lowCnt;
    logic [BAUD_W+3:0] breakCnt;
    logic              rxPrev;

    wire fallEdge = rxPrev && !rxLine;
    wire riseEdge = !rxPrev && rxLine;
    wire measOvf  = (lowCnt == `DCD_BAUD_MAX);
    // The calibration character shows the start bit plus seven zero bits low.
    wire [BAUD_W-1:0] measBit = lowCnt >> 3;
    // The current low cycle counts too, so exactly ten bit times are enough for a break.
    wire breakHit = baudLocked && !rxLine &&
                    ((breakCnt + (BAUD_W+4)'(1)) >=
                     (BAUD_W+4)'(baudReload) * (BAUD_W+4)'(`DCD_BREAK_BITS));

    always_comb begin
        next_state = state;
        case (state)
            AB_IDLE:    if (fallEdge) next_state = AB_MEASURE;
            AB_MEASURE: begin
                if (measOvf) next_state = AB_IDLE;
                else if (riseEdge) next_state = AB_LOCKED;
            end
            AB_LOCKED:  if (breakHit) next_state = AB_IDLE;
            default:    next_state = AB_IDLE;
        endcase
    end

    assign baudLocked = (state == AB_LOCKED);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state      <= AB_IDLE;
            lowCnt     <= '0;
            breakCnt   <= '0;
            rxPrev     <= 1'b1;
            baudReload <= '0;
            breakSeen  <= 1'b0;
        end else begin
            state     <= next_state;
            rxPrev    <= rxLine;
            breakSeen <= breakHit;
            // Counting starts in the cycle of the falling edge, so every low cycle is seen.
            lowCnt    <= (next_state == AB_MEASURE) ? lowCnt + BAUD_W'(1) : '0;
            breakCnt  <= rxLine ? '0 : breakCnt + (BAUD_W+4)'(1);
            if (state == AB_MEASURE && riseEdge && !measOvf) begin
                baudReload <= (measBit == '0) ? BAUD_W'(1) : measBit;
            end else if (breakHit) begin
                baudReload <= '0;
            end
        end
    end
endmodule
`default_nettype wire

// ### rtl/dcd_decoder.sv
// Command decoder of the single-pin serial debug unit.
// Assumes command bytes arrive decoded from the serial link with their target address,
// and that coreDebug and readProtect are levels from logic on clk_sys.
`timescale 1ns/1ps
`default_nettype none
`include "dcd_defines.svh"
module dcd_decoder
    import dcd_pkg::*;
#(
    parameter int FIFO_DEPTH = `DCD_FIFO_DEPTH,
    parameter int BAUD_W     = `DCD_BAUD_W
) (
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    input  wire logic              rxPin,
    input  wire dcd_cmd_s          cmdIn,
    input  wire logic              cmdValid,
    output logic                   cmdReady,
    input  wire logic              coreDebug,
    input  wire logic              readProtect,
    input  wire logic [7:0]        wrData,
    output dcd_result_s            result,
    output logic                   resultValid,
    input  wire logic              resultReady,
    output logic [7:0]             counterReg,
    output logic [7:0]             controlReg,
    output logic [7:0]             lineCtlReg,
    output logic                   coreWrite,
    output logic                   coreAccess,
    output logic [BAUD_W-1:0]      baudReload,
    output logic                   baudLocked,
    output logic                   breakSeen
);
    localparam int CMD_W = $bits(dcd_cmd_s);

    logic     rxMeta;
    logic     rxSync;
    dcd_cmd_s head;
    logic     headValid;
    logic     headReady;
    logic     fifoReady;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rxMeta <= 1'b1;
            rxSync <= 1'b1;
        end else begin
            rxMeta <= rxPin;
            rxSync <= rxMeta;
        end
    end

    assign cmdReady = fifoReady;

    dcd_fifo #(
        .WIDTH (CMD_W),
        .DEPTH (FIFO_DEPTH)
    ) uFifo (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .inData   (cmdIn),
        .inValid  (cmdValid),
        .inReady  (fifoReady),
        .outData  (head),
        .outValid (headValid),
        .outReady (headReady)
    );

    dcd_autobaud #(
        .BAUD_W (BAUD_W)
    ) uBaud (
        .clk_sys    (clk_sys),
        .rst_n      (rst_n),
        .rxLine     (rxSync),
        .baudReload (baudReload),
        .baudLocked (baudLocked),
        .breakSeen  (breakSeen)
    );

    function automatic logic isRam(input logic [11:0] addr);
        isRam = (addr >= `DCD_RAM_BASE) && (addr <= `DCD_RAM_TOP);
    endfunction

    function automatic logic inRange(input logic [7:0] c, input logic [7:0] lo,
                                     input logic [7:0] hi);
        inRange = (c >= lo) && (c <= hi);
    endfunction

    wire [7:0] code = head.code;

    // Commands honoured outside the debug state.
    wire anyState = (code == `DCD_CMD_RD_REV) || (code == `DCD_CMD_RD_STAT) ||
                    (code == `DCD_CMD_WR_CTL) || (code == `DCD_CMD_RD_CTL);

    wire fullyProt = inRange(code, `DCD_CMD_WR_PC, `DCD_CMD_RD_PC) ||
                     inRange(code, `DCD_CMD_WR_PMEM, `DCD_CMD_RD_DMEM) ||
                     inRange(code, `DCD_CMD_STEP, `DCD_CMD_EXEC);

    wire regAccess = (code == `DCD_CMD_WR_REG) || (code == `DCD_CMD_RD_REG);
    wire ramTarget = head.hasAddr && isRam(head.addr);
    wire ramProt   = regAccess && readProtect && ramTarget;

    wire known = anyState || fullyProt || regAccess ||
                 inRange(code, `DCD_CMD_WR_CNT, `DCD_CMD_WR_CNT) ||
                 (code == `DCD_CMD_RD_CNT) || (code == `DCD_CMD_RD_CRC) ||
                 (code == `DCD_CMD_WR_LINE) || (code == `DCD_CMD_RD_LINE) ||
                 (code == `DCD_CMD_RD_BAUD);

    // All other commands, counter and line control writes included, need the debug state.
    wire stateRefused = !anyState && !coreDebug;
    dcd_verdict_e verdict;
    assign verdict = !known                          ? DCD_REF_RSVD :
                     stateRefused                    ? DCD_REF_STATE :
                     (readProtect && fullyProt)      ? DCD_REF_PROT :
                     ramProt                         ? DCD_REF_PROT :
                                                       DCD_OK;

    wire take     = headValid && headReady;
    wire accepted = take && (verdict == DCD_OK);
    wire writesCore = (code == `DCD_CMD_WR_PC) || (code == `DCD_CMD_WR_REG) ||
                      (code == `DCD_CMD_WR_PMEM) || (code == `DCD_CMD_WR_DMEM) ||
                      inRange(code, `DCD_CMD_STEP, `DCD_CMD_EXEC);

    // A result slot frees when the holder drains it; back-pressure stalls the FIFO.
    assign headReady = !resultValid || resultReady;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            resultValid <= 1'b0;
            result      <= '0;
        end else begin
            if (take) begin
                resultValid      <= 1'b1;
                result.code      <= code;
                result.verdict   <= verdict;
                result.ramTarget <= ramTarget;
            end else if (resultReady) begin
                resultValid <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            counterReg <= 8'h00;
            controlReg <= 8'h00;
            lineCtlReg <= 8'h00;
            coreWrite  <= 1'b0;
            coreAccess <= 1'b0;
        end else begin
            coreWrite  <= accepted && writesCore;
            coreAccess <= accepted && !anyState;
            if (accepted && code == `DCD_CMD_WR_CNT) begin
                counterReg <= wrData;
            end
            if (accepted && code == `DCD_CMD_WR_CTL) begin
                controlReg <= wrData;
            end
            if (accepted && code == `DCD_CMD_WR_LINE) begin
                lineCtlReg <= wrData;
            end
        end
    end
endmodule
`default_nettype wire

// ### dv/dcd_decoder_monitor.sv
// Checker of the debug command decoder ports.
// Assumes it is bound to every dcd_decoder instance by the bind at the foot.
`timescale 1ns/1ps
`default_nettype none
module dcd_decoder_monitor
    import dcd_pkg::*;
#(
    parameter int BAUD_W = 12
) (
    input wire logic              clk_sys,
    input wire logic              rst_n,
    input wire logic              rxPin,
    input wire dcd_cmd_s          cmdIn,
    input wire logic              cmdValid,
    input wire logic              cmdReady,
    input wire logic              coreDebug,
    input wire logic              readProtect,
    input wire logic [7:0]        wrData,
    input wire dcd_result_s       result,
    input wire logic              resultValid,
    input wire logic              resultReady,
    input wire logic [7:0]        counterReg,
    input wire logic [7:0]        controlReg,
    input wire logic [7:0]        lineCtlReg,
    input wire logic              coreWrite,
    input wire logic              coreAccess,
    input wire logic [BAUD_W-1:0] baudReload,
    input wire logic              baudLocked,
    input wire logic              breakSeen
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    result_hold_a: assert property (resultValid && !resultReady
        |=> resultValid && $stable(result)) else $error("result changed while stalled");
    counter_write_a: assert property ($changed(counterReg) |-> resultValid
        && result.code == 8'h01 && result.verdict == DCD_OK) else $error("counter write bad");
    line_write_a: assert property ($changed(lineCtlReg) |-> resultValid
        && result.code == 8'h18 && result.verdict == DCD_OK) else $error("line write bad");
    free_codes_a: assert property ($rose(resultValid)
        && result.code inside {8'h00, 8'h02, 8'h04, 8'h05} |-> result.verdict == DCD_OK)
        else $error("free code refused");
    debug_only_a: assert property ($rose(resultValid) && !$past(coreDebug)
        && result.code inside {8'h01, 8'h03, 8'h0E, 8'h18, 8'h19, 8'h1B}
        |-> result.verdict == DCD_REF_STATE) else $error("debug only code taken");
    protect_refuse_a: assert property ($rose(resultValid) && $past(coreDebug)
        && $past(readProtect) && result.code inside {8'h06, 8'h07, [8'h0A:8'h0D], [8'h10:8'h12]}
        |-> result.verdict == DCD_REF_PROT) else $error("protected code taken");
    reserved_code_a: assert property ($rose(resultValid) && result.code == 8'h0F
        |-> result.verdict == DCD_REF_RSVD) else $error("reserved code taken");
    ram_write_a: assert property (coreWrite && result.code == 8'h08
        |-> !(result.ramTarget && $past(readProtect))) else $error("protected RAM written");
    access_ok_a: assert property (coreAccess
        |-> result.verdict == DCD_OK && $past(coreDebug))
        else $error("refused command reached core");
    break_reset_a: assert property (breakSeen
        |-> ##[0:1] (!baudLocked && baudReload == '0)) else $error("break left baud locked");
    cover property ($rose(baudLocked));
    cover property (breakSeen);
    cover property ($rose(resultValid) && result.verdict == DCD_REF_PROT);
endmodule
bind dcd_decoder dcd_decoder_monitor #(.BAUD_W(BAUD_W)) mon (
    .clk_sys     (clk_sys),
    .rst_n       (rst_n),
    .rxPin       (rxPin),
    .cmdIn       (cmdIn),
    .cmdValid    (cmdValid),
    .cmdReady    (cmdReady),
    .coreDebug   (coreDebug),
    .readProtect (readProtect),
    .wrData      (wrData),
    .result      (result),
    .resultValid (resultValid),
    .resultReady (resultReady),
    .counterReg  (counterReg),
    .controlReg  (controlReg),
    .lineCtlReg  (lineCtlReg),
    .coreWrite   (coreWrite),
    .coreAccess  (coreAccess),
    .baudReload  (baudReload),
    .baudLocked  (baudLocked),
    .breakSeen   (breakSeen)
);
`default_nettype wire

// ### dv/dcd_host_model.sv
// Debug host model driving the single serial debug line.
// Assumes a pulled-up line, so released means high.
`timescale 1ns/1ps
`default_nettype none
module dcd_host_model (
    input  wire logic clk_sys,
    output logic      rxLine
);
    initial rxLine = 1'b1;
    // Holds the line low for a number of system clocks.
    task automatic hold_low(input int cycles);
        @(posedge clk_sys);
        #1 rxLine = 1'b0;
        repeat (cycles) @(posedge clk_sys);
        #1 rxLine = 1'b1;
    endtask
    // Sends the calibration character, start bit then bits from the least significant.
    task automatic recal(input int bitCycles);
        logic [9:0] frame;
        frame = {1'b1, 8'h80, 1'b0};
        @(posedge clk_sys);
        for (int i = 0; i < 10; i++) begin
            #1 rxLine = frame[i];
            repeat (bitCycles) @(posedge clk_sys);
        end
        #1 rxLine = 1'b1;
    endtask
endmodule
`default_nettype wire

// ### dv/tb_top.sv
// Self-checking bench of the debug command decoder.
// Assumes the host model drives the serial line; the bench drives the command side.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import dcd_pkg::*;
    localparam int BIT = 16;
    logic        clk_sys = 1'b0, rst_n = 1'b0, cmdValid = 1'b0, resultReady = 1'b0;
    logic        coreDebug = 1'b0, readProtect = 1'b0, lastWrite;
    logic [7:0]  wrData = 8'h00, counterReg, controlReg, lineCtlReg;
    dcd_cmd_s    cmdIn = '0;
    dcd_result_s result;
    logic        rxPin, cmdReady, resultValid, coreWrite, coreAccess, baudLocked, breakSeen;
    logic [11:0] baudReload;
    int          errors = 0;
    int          samples_checked = 0;
    always #2.5 clk_sys = ~clk_sys;
    dcd_host_model host (.clk_sys, .rxLine(rxPin));
    dcd_decoder #(.FIFO_DEPTH(8), .BAUD_W(12)) dut (.clk_sys, .rst_n, .rxPin, .cmdIn, .cmdValid,
        .cmdReady, .coreDebug, .readProtect, .wrData, .result, .resultValid, .resultReady,
        .counterReg, .controlReg, .lineCtlReg, .coreWrite, .coreAccess, .baudReload,
        .baudLocked, .breakSeen);
    task automatic check(input logic ok, input string msg);
        samples_checked++;
        if (ok !== 1'b1) begin
            errors++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask
    task automatic cmd(input logic [7:0] code, input logic [11:0] addr, input logic dbg,
                       input logic prot, input logic [7:0] data, input dcd_verdict_e exp);
        int n;
        logic isWr;
        logic isFree;
        n = 0;
        isWr = code inside {8'h06, 8'h08, 8'h0A, 8'h0C, [8'h10:8'h12]};
        isFree = code inside {8'h00, 8'h02, 8'h04, 8'h05};
        coreDebug = dbg;
        readProtect = prot;
        wrData = data;
        cmdIn = {code, addr, 1'b1};
        cmdValid = 1'b1;
        @(posedge clk_sys);
        #1 cmdValid = 1'b0;
        while (resultValid !== 1'b1 && n < 20) begin
            @(posedge clk_sys);
            #1 n++;
        end
        lastWrite = coreWrite;
        check(resultValid === 1'b1 && result.code === code && result.verdict === exp, "verdict");
        if (exp != DCD_OK) check(coreWrite === 1'b0 && coreAccess === 1'b0, "pulse");
        if (exp == DCD_OK) check(coreWrite === isWr && coreAccess === !isFree, "core");
        resultReady = 1'b1;
        @(posedge clk_sys);
        #1 resultReady = 1'b0;
    endtask
    task automatic t_state;
        logic [7:0] ok[4] = '{8'h00, 8'h02, 8'h04, 8'h05};
        logic [7:0] dbg[10] = '{8'h01, 8'h03, 8'h06, 8'h08, 8'h09,
                                8'h0E, 8'h10, 8'h18, 8'h19, 8'h1B};
        check(counterReg === 8'h00 && controlReg === 8'h00 && cmdReady === 1'b1, "reset");
        foreach (ok[i]) cmd(ok[i], 12'hF00, 1'b0, 1'b0, 8'h00, DCD_OK);
        foreach (dbg[i]) cmd(dbg[i], 12'hF00, 1'b0, 1'b0, 8'h5A, DCD_REF_STATE);
        check(counterReg === 8'h00 && lineCtlReg === 8'h00, "refused write");
    endtask
    task automatic t_prot;
        logic [7:0] pc[9] = '{8'h06, 8'h07, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h10, 8'h11, 8'h12};
        logic [7:0] ac[8] = '{8'h01, 8'h03, 8'h04, 8'h05, 8'h0E, 8'h18, 8'h19, 8'h1B};
        logic [7:0] rc[4] = '{8'h0F, 8'h13, 8'h1A, 8'hFF};
        foreach (pc[i]) cmd(pc[i], 12'hF00, 1'b1, 1'b1, 8'h00, DCD_REF_PROT);
        foreach (pc[i]) cmd(pc[i], 12'hF00, 1'b1, 1'b0, 8'h00, DCD_OK);
        foreach (ac[i]) cmd(ac[i], 12'hF00, 1'b1, 1'b1, 8'h00, DCD_OK);
        cmd(8'h08, 12'hEFF, 1'b1, 1'b1, 8'h00, DCD_REF_PROT);
        cmd(8'h08, 12'hEFF, 1'b1, 1'b0, 8'h00, DCD_OK);
        cmd(8'h08, 12'hF00, 1'b1, 1'b1, 8'h00, DCD_OK);
        check(lastWrite === 1'b1, "peripheral write");
        cmd(8'h09, 12'h010, 1'b1, 1'b1, 8'h00, DCD_REF_PROT);
        cmd(8'h09, 12'hF00, 1'b1, 1'b1, 8'h00, DCD_OK);
        foreach (rc[i]) cmd(rc[i], 12'hF00, 1'b1, 1'b0, 8'h00, DCD_REF_RSVD);
    endtask
    task automatic t_regs;
        cmd(8'h01, 12'hF00, 1'b1, 1'b0, 8'hA5, DCD_OK);
        cmd(8'h04, 12'hF00, 1'b0, 1'b0, 8'h3C, DCD_OK);
        cmd(8'h18, 12'hF00, 1'b1, 1'b0, 8'hC3, DCD_OK);
        cmd(8'h18, 12'hF00, 1'b0, 1'b0, 8'h11, DCD_REF_STATE);
        check({counterReg, controlReg, lineCtlReg} === 24'hA53CC3, "registers");
    endtask
    task automatic t_reset;
        rst_n = 1'b0;
        repeat (2) @(posedge clk_sys);
        #1 rst_n = 1'b1;
        check({counterReg, controlReg, lineCtlReg} === 24'h000000 && resultValid === 1'b0
              && cmdReady === 1'b1 && baudLocked === 1'b0, "mid-run reset");
    endtask
    task automatic t_fifo;
        int n = 0;
        int m = 0;
        coreDebug = 1'b1;
        readProtect = 1'b0;
        cmdIn = {8'h02, 12'h000, 1'b0};
        cmdValid = 1'b1;
        repeat (14) begin
            if (cmdReady === 1'b1) n++;
            @(posedge clk_sys);
            #1;
        end
        cmdValid = 1'b0;
        // Eight words fit in the queue and one more waits in the result slot.
        check(cmdReady === 1'b0 && n == 8 + 1, "fill level");
        resultReady = 1'b1;
        repeat (30) begin
            if (resultValid === 1'b1) m++;
            @(posedge clk_sys);
            #1;
        end
        resultReady = 1'b0;
        check(m == n && resultValid === 1'b0 && cmdReady === 1'b1, "drain count");
    endtask
    task automatic t_baud;
        int n = 0;
        host.recal(BIT);
        repeat (4) @(posedge clk_sys);
        check(baudLocked === 1'b1 && baudReload === 12'(BIT), "baud lock");
        cmd(8'h1B, 12'hF00, 1'b1, 1'b0, 8'h00, DCD_OK);
        fork
            host.hold_low(10 * BIT + 4);
            while (breakSeen !== 1'b1 && n < 250) begin
                @(posedge clk_sys);
                #1 n++;
            end
        join
        repeat (2) @(posedge clk_sys);
        check(n < 250 && baudLocked === 1'b0 && baudReload === 12'h000, "break");
        host.hold_low(5000);
        repeat (4) @(posedge clk_sys);
        check(baudLocked === 1'b0 && baudReload === 12'h000, "overflow");
        host.recal(BIT);
        repeat (4) @(posedge clk_sys);
        check(baudLocked === 1'b1 && baudReload === 12'(BIT), "relock");
    endtask
    task automatic finish_test;
        if (errors == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk_sys);
        #1 rst_n = 1'b1;
        t_state();
        t_prot();
        t_regs();
        t_reset();
        t_fifo();
        t_baud();
        finish_test();
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        errors++;
        finish_test();
    end
endmodule
`default_nettype wire
